// >>> rtl/wbl_consts.svh
// offsets, fields, reset values and sizes of the white balance tables
// How it works
// RULE1 - host fills all three tables, 256 entries of 8 bits each
// RULE2 - below 8-bit depth, host writes zero into unused low bits
// RULE3 - for 8-bit in and out, host loads 256 distinct values per table
// RULE4 - in 8-bit operation the table value goes to the display output
// RULE5 - 6-bit direct: entries hold 6 upper bits, low two zero
// RULE6 - 6-bit in, 8-bit entries: second dither stage reduces to 6 bits
// RULE7 - host loads all three tables before setting white balance enable
// RULE8 - first load goes red, green, blue, page selected before each table
// RULE9 - after initial load, table writes refused unless reload is enabled
// RULE10 - with reload on, rewrites accepted while white balance stays on
// RULE11 - new table values take effect without disturbing the pixel stream
// RULE12 - reload may rewrite any subset of entries or tables
// RULE13 - control bits 7:6 select page: config, red, green, blue
// RULE14 - control bit 5 enables white balance; register resets to zero
// RULE15 - control bit 4 permits reload; bits 3:0 reserved
// RULE16 - on pages 1 to 3 offsets 00..FF map onto the table entries
// RULE17 - when enabled each subpixel is replaced by its table entry
// RULE18 - second dither stage follows the tables, first stage precedes
// RULE19 - 6-bit input indexes the table left aligned, low two bits zero
// RULE20 - when disabled pixels pass unchanged with the same latency
`ifndef WBL_CONSTS_SVH
`define WBL_CONSTS_SVH
`define WBL_CTRL_ADDR      8'h2A
`define WBL_STAT_ADDR      8'h2B
`define WBL_CTRL_RESET     8'h00
`define WBL_PAGE_HI        7
`define WBL_PAGE_LO        6
`define WBL_EN_BIT         5
`define WBL_RELOAD_BIT     4
`define WBL_CTRL_WR_MASK   8'hF0
`define WBL_PAGE_CONFIG    2'h0
`define WBL_PAGE_RED       2'h1
`define WBL_PAGE_GREEN     2'h2
`define WBL_PAGE_BLUE      2'h3
`define WBL_DEPTH          256
`define WBL_WIDTH          8
`define WBL_CTL_WIDTH      3
`endif

// >>> rtl/wbl_pkg.sv
// types shared by the white balance table block
package wbl_pkg;
  typedef logic [7:0] wbl_byte_t;
  typedef logic [1:0] wbl_page_t;
  // initial load progress, one-hot
  typedef enum logic [3:0] {
    WBL_LOAD_RED   = 4'b0001,
    WBL_LOAD_GREEN = 4'b0010,
    WBL_LOAD_BLUE  = 4'b0100,
    WBL_LOAD_DONE  = 4'b1000
  } wbl_load_t;
endpackage

// >>> rtl/wbl_table.sv
// one colour table: 256 x 8 array, host port and pixel lookup port
`timescale 1ns/100ps
`include "wbl_consts.svh"
module wbl_table
  import wbl_pkg::*;
(
  // clock
  input  wire logic      clk_sys,
  input  wire logic      ce,
  // host side
  input  wire logic      wr_en,
  input  wire wbl_byte_t host_addr,
  input  wire wbl_byte_t wr_data,
  output wbl_byte_t      host_rdata,
  // pixel side
  input  wire wbl_byte_t pix_addr,
  output wbl_byte_t      pix_data
);
  // entries carry no reset value
  wbl_byte_t mem [0:`WBL_DEPTH-1];

  // separate write and lookup ports: a rewrite never stalls the pixel path
  always_ff @(posedge clk_sys) begin
    if (ce && wr_en) begin
      mem[host_addr] <= wr_data; // [RULE12] [RULE16]
    end
  end

  // lookup, one cycle; a new entry shows from the next pixel on
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      pix_data <= mem[pix_addr]; // [RULE11] [RULE17]
    end
  end

  assign host_rdata = mem[host_addr];
endmodule

// >>> rtl/wbl_fill_track.sv
// records which entries of one table have been written since reset
`timescale 1ns/100ps
`include "wbl_consts.svh"
module wbl_fill_track
  import wbl_pkg::*;
(
  // clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  input  wire logic      ce,
  // write watch
  input  wire logic      wr_en,
  input  wire wbl_byte_t wr_addr,
  // state
  output logic           full
);
  logic [`WBL_DEPTH-1:0] seen;

  // one flag per entry, so rewriting an entry does not count twice
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seen <= '0;
    end else if (ce && wr_en) begin
      seen[wr_addr] <= 1'b1;
    end
  end

  assign full = &seen;
endmodule

// >>> rtl/wbl_top.sv
// white balance stage: paged control register, three tables, pixel path
`timescale 1ns/100ps
`include "wbl_consts.svh"
module wbl_top
  import wbl_pkg::*;
(
  // clock, enable and reset
  input  wire logic                      clk_sys,
  input  wire logic                      ce,
  input  wire logic                      rst,
  // control bus register port
  input  wire wbl_byte_t                 reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire wbl_byte_t                 reg_wdata,
  output wbl_byte_t                      reg_rdata,
  output logic                           reg_rvalid,
  // mode inputs from other configuration
  input  wire logic                      in_6bit,
  input  wire logic                      second_dither_stage_en,
  // pixels from the first dither stage
  input  wire logic                      pix_in_valid,
  input  wire logic [`WBL_CTL_WIDTH-1:0] pix_in_ctl,
  input  wire wbl_byte_t                 pix_in_r,
  input  wire wbl_byte_t                 pix_in_g,
  input  wire wbl_byte_t                 pix_in_b,
  // pixels toward the second dither stage
  output logic                           pix_out_valid,
  output logic [`WBL_CTL_WIDTH-1:0]      pix_out_ctl,
  output wbl_byte_t                      pix_out_r,
  output wbl_byte_t                      pix_out_g,
  output wbl_byte_t                      pix_out_b,
  output logic                           dither_needed,
  output logic                           wb_active
);
  wbl_byte_t colour_correction_control;
  wbl_page_t page;
  logic      wb_en;
  logic      reload_en;
  logic      init_locked;
  logic      table_page;
  logic      tables_writable;
  logic      ctrl_hit;
  logic      stat_hit;
  logic      wr_red;
  logic      wr_green;
  logic      wr_blue;
  logic      full_red;
  logic      full_green;
  logic      full_blue;
  wbl_load_t load_state;
  wbl_load_t next_load_state;
  wbl_byte_t host_red;
  wbl_byte_t host_green;
  wbl_byte_t host_blue;
  wbl_byte_t next_rdata;
  wbl_byte_t status;
  wbl_byte_t idx_r;
  wbl_byte_t idx_g;
  wbl_byte_t idx_b;
  wbl_byte_t lut_r;
  wbl_byte_t lut_g;
  wbl_byte_t lut_b;
  wbl_byte_t byp_r;
  wbl_byte_t byp_g;
  wbl_byte_t byp_b;
  logic      s1_valid;
  logic      s1_wb;
  logic      s1_6bit;
  logic      s1_dith;
  logic [`WBL_CTL_WIDTH-1:0] s1_ctl;

  // control register fields
  assign page      = colour_correction_control[`WBL_PAGE_HI:`WBL_PAGE_LO];
  assign wb_en     = colour_correction_control[`WBL_EN_BIT];
  assign reload_en = colour_correction_control[`WBL_RELOAD_BIT];

  // address decode depends on the page in force when the access arrives
  assign table_page = (page != `WBL_PAGE_CONFIG); // [RULE13]
  assign ctrl_hit   = !table_page && (reg_addr == `WBL_CTRL_ADDR);
  assign stat_hit   = !table_page && (reg_addr == `WBL_STAT_ADDR);

  // writes to the tables close once the initial load is over
  assign tables_writable = !init_locked || reload_en; // [RULE9] [RULE10]

  // whole page maps one-to-one onto the 256 entries of the chosen table
  assign wr_red   = reg_wr && tables_writable
                    && (page == `WBL_PAGE_RED);   // [RULE16]
  assign wr_green = reg_wr && tables_writable
                    && (page == `WBL_PAGE_GREEN); // [RULE16]
  assign wr_blue  = reg_wr && tables_writable
                    && (page == `WBL_PAGE_BLUE);  // [RULE16]

  // control register; reserved low nibble is never stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      colour_correction_control <= `WBL_CTRL_RESET; // [RULE14]
    end else if (ce && reg_wr && ctrl_hit) begin
      colour_correction_control <= reg_wdata
                                   & `WBL_CTRL_WR_MASK; // [RULE14] [RULE15]
    end
  end

  // the first setting of the enable ends the initial load for good;
  // software that enables early simply locks a partly filled table
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      init_locked <= 1'b0;
    end else if (ce && wb_en) begin
      init_locked <= 1'b1; // [RULE9]
    end
  end

  // progress of the red, green, blue initial sequence, shown in status
  always_comb begin
    next_load_state = load_state;
    case (load_state)
      WBL_LOAD_RED: begin
        if (full_red) begin
          next_load_state = WBL_LOAD_GREEN;
        end
      end
      WBL_LOAD_GREEN: begin
        if (full_green) begin
          next_load_state = WBL_LOAD_BLUE;
        end
      end
      WBL_LOAD_BLUE: begin
        if (full_blue) begin
          next_load_state = WBL_LOAD_DONE;
        end
      end
      WBL_LOAD_DONE: begin
        next_load_state = WBL_LOAD_DONE;
      end
      default: begin
        next_load_state = WBL_LOAD_RED;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_state <= WBL_LOAD_RED;
    end else if (ce) begin
      load_state <= next_load_state; // [RULE8]
    end
  end

  // fill trackers let software confirm that every entry was written
  wbl_fill_track u_fill_red (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (wr_red),
    .wr_addr (reg_addr),
    .full    (full_red)
  );

  wbl_fill_track u_fill_green (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (wr_green),
    .wr_addr (reg_addr),
    .full    (full_green)
  );

  wbl_fill_track u_fill_blue (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (wr_blue),
    .wr_addr (reg_addr),
    .full    (full_blue)
  );

  // status word: load phase, tables full, initial load closed
  assign status = {load_state, full_blue, full_green, full_red,
                   init_locked};

  // register read, answered one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    case (page)
      `WBL_PAGE_RED: begin
        next_rdata = host_red; // [RULE16]
      end
      `WBL_PAGE_GREEN: begin
        next_rdata = host_green;
      end
      `WBL_PAGE_BLUE: begin
        next_rdata = host_blue;
      end
      default: begin
        if (ctrl_hit) begin
          next_rdata = colour_correction_control; // [RULE15]
        end else if (stat_hit) begin
          next_rdata = status;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // 6-bit input sits in bits 7:2; low two index bits forced to zero
  assign idx_r = in_6bit ? {pix_in_r[7:2], 2'b00} : pix_in_r; // [RULE19]
  assign idx_g = in_6bit ? {pix_in_g[7:2], 2'b00} : pix_in_g; // [RULE19]
  assign idx_b = in_6bit ? {pix_in_b[7:2], 2'b00} : pix_in_b; // [RULE19]

  // the three colour tables, each looked up with its own subpixel
  wbl_table u_table_red (
    .clk_sys    (clk_sys),
    .ce         (ce),
    .wr_en      (wr_red),
    .host_addr  (reg_addr),
    .wr_data    (reg_wdata),
    .host_rdata (host_red),
    .pix_addr   (idx_r),
    .pix_data   (lut_r)
  );

  wbl_table u_table_green (
    .clk_sys    (clk_sys),
    .ce         (ce),
    .wr_en      (wr_green),
    .host_addr  (reg_addr),
    .wr_data    (reg_wdata),
    .host_rdata (host_green),
    .pix_addr   (idx_g),
    .pix_data   (lut_g)
  );

  wbl_table u_table_blue (
    .clk_sys    (clk_sys),
    .ce         (ce),
    .wr_en      (wr_blue),
    .host_addr  (reg_addr),
    .wr_data    (reg_wdata),
    .host_rdata (host_blue),
    .pix_addr   (idx_b),
    .pix_data   (lut_b)
  );

  // stage one: bypass copy runs beside the lookup so both paths match
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_valid <= 1'b0;
      s1_ctl   <= '0;
      s1_wb    <= 1'b0;
      s1_6bit  <= 1'b0;
      s1_dith  <= 1'b0;
      byp_r    <= 8'h00;
      byp_g    <= 8'h00;
      byp_b    <= 8'h00;
    end else if (ce) begin
      s1_valid <= pix_in_valid;
      s1_ctl   <= pix_in_ctl;
      s1_wb    <= wb_en; // sampled per pixel: switching never tears one
      s1_6bit  <= in_6bit;
      s1_dith  <= second_dither_stage_en; // flag follows its own pixel
      byp_r    <= pix_in_r; // [RULE20]
      byp_g    <= pix_in_g;
      byp_b    <= pix_in_b;
    end
  end

  // stage two: pick table or bypass; output feeds the second dither stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pix_out_valid <= 1'b0;
      pix_out_ctl   <= '0;
      pix_out_r     <= 8'h00;
      pix_out_g     <= 8'h00;
      pix_out_b     <= 8'h00;
    end else if (ce) begin
      pix_out_valid <= s1_valid;
      pix_out_ctl   <= s1_ctl;
      pix_out_r     <= s1_wb ? lut_r : byp_r; // [RULE4] [RULE17] [RULE18]
      pix_out_g     <= s1_wb ? lut_g : byp_g; // [RULE4] [RULE17] [RULE20]
      pix_out_b     <= s1_wb ? lut_b : byp_b; // [RULE4] [RULE17] [RULE5]
    end
  end

  // full 8-bit entries on 6-bit input must be dithered down downstream
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dither_needed <= 1'b0;
      wb_active     <= 1'b0;
    end else if (ce) begin
      dither_needed <= s1_wb && s1_6bit && s1_dith; // [RULE6]
      wb_active     <= s1_wb;
    end
  end
endmodule

// >>> sim/wbl_top_sva.sv
// port assertions for the white balance stage
`timescale 1ns/100ps
`include "wbl_consts.svh"
module wbl_top_sva
  import wbl_pkg::*;
(
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      ce,
  input wire logic                      rst,
  // register port
  input wire wbl_byte_t                 reg_addr,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire wbl_byte_t                 reg_rdata,
  input wire logic                      reg_rvalid,
  // pixel path
  input wire logic                      in_6bit,
  input wire logic                      second_dither_stage_en,
  input wire logic                      pix_in_valid,
  input wire logic [`WBL_CTL_WIDTH-1:0] pix_in_ctl,
  input wire wbl_byte_t                 pix_in_r,
  input wire logic                      pix_out_valid,
  input wire logic [`WBL_CTL_WIDTH-1:0] pix_out_ctl,
  input wire wbl_byte_t                 pix_out_r,
  input wire logic                      dither_needed,
  input wire logic                      wb_active
);
  logic [1:0] run_h;
  logic       fresh;
  wire        run2 = ce && (run_h == 2'b11);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // two clean enabled edges behind, so a two-deep past is a real pixel
  always_ff @(posedge clk_sys) begin
    run_h <= {run_h[0], ce & ~rst};
  end
  // no register write of any kind since reset
  always_ff @(posedge clk_sys) begin
    if (rst) fresh <= 1'b1;
    else if (ce && reg_wr) fresh <= 1'b0;
  end
  sequence rd_req;
    ce && reg_rd;
  endsequence
  sequence ctl_rd;
    fresh && ce && reg_rd && reg_addr == `WBL_CTRL_ADDR;
  endsequence
  valid_delay_a: assert property (
    run2 |-> pix_out_valid == $past(pix_in_valid, 2))
    else $error("pixel valid not two cycles late");
  ctl_delay_a: assert property (
    run2 |-> pix_out_ctl == $past(pix_in_ctl, 2))
    else $error("sync bits not two cycles late");
  bypass_pass_a: assert property (
    run2 && !wb_active |-> pix_out_r == $past(pix_in_r, 2))
    else $error("bypass pixel changed");
  rd_answer_a: assert property (
    rd_req |=> reg_rvalid)
    else $error("read not answered next cycle");
  rvalid_cause_a: assert property (
    reg_rvalid |-> $past(reg_rd) && $past(ce))
    else $error("read answer without request");
  ctl_reset_a: assert property (
    ctl_rd |=> reg_rdata == `WBL_CTRL_RESET)
    else $error("control not zero after reset");
  rdata_hold_a: assert property (
    !$past(rst) && !reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  dither_flag_a: assert property (
    run2 |-> dither_needed == (wb_active && $past(in_6bit, 2)
                               && $past(second_dither_stage_en, 2)))
    else $error("dither flag wrong");
endmodule

// >>> sim/wbl_host.sv
// host controller model on the control bus register port
`timescale 1ns/100ps
`include "wbl_consts.svh"
module wbl_host
  import wbl_pkg::*;
(
  // clock
  input  wire logic      clk_sys,
  // register port
  output wbl_byte_t      reg_addr,
  output logic           reg_wr,
  output logic           reg_rd,
  output wbl_byte_t      reg_wdata,
  input  wire wbl_byte_t reg_rdata
);
  // bus idle at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // strobe stays up across back to back writes; idle drops it
  task automatic wr(input wbl_byte_t a, input wbl_byte_t d);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
  endtask
  // released lines toggle so a stale value never looks valid
  task automatic idle();
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_addr  <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
    @(posedge clk_sys);
  endtask
  // answer is taken at the edge where the read valid stands
  task automatic rd(input wbl_byte_t a, output wbl_byte_t d);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask
  // whole table, page chosen first, full distinct 8-bit entries
  task automatic fill(input wbl_page_t pg, input wbl_byte_t k);
    wr(`WBL_CTRL_ADDR, {pg, 6'h00});
    for (int i = 0; i < 256; i++) begin
      wr(8'(i), 8'(i) ^ k);
    end
    idle();
  endtask
endmodule

// >>> sim/test_wbl_top.sv
// self-checking bench for the white balance stage
`timescale 1ns/100ps
`include "wbl_consts.svh"
module test_wbl_top
  import wbl_pkg::*;
;
  logic                      clk_sys = 1'b0;
  logic                      rst = 1'b1;
  logic                      ce = 1'b1;
  logic                      in_6bit = 1'b0;
  logic                      dither_en = 1'b0;
  logic                      pix_in_valid = 1'b0;
  logic [`WBL_CTL_WIDTH-1:0] pix_in_ctl = '0;
  logic [`WBL_CTL_WIDTH-1:0] pix_out_ctl;
  wbl_byte_t                 pix_in_r = 8'h00;
  wbl_byte_t                 pix_in_g = 8'h00;
  wbl_byte_t                 pix_in_b = 8'h00;
  wbl_byte_t                 reg_addr, reg_wdata, reg_rdata, rdat;
  wbl_byte_t                 pix_out_r, pix_out_g, pix_out_b;
  logic                      reg_wr, reg_rd, reg_rvalid, pix_out_valid;
  logic                      dither_needed, wb_active;
  wbl_byte_t                 key [4] = '{8'h00, 8'h5A, 8'hC3, 8'h96};
  wbl_byte_t                 patch = 8'h00;
  int                        failures = 0;
  int                        checks_done = 0;
  // free running system clock
  always #5 clk_sys = ~clk_sys;
  wbl_top dut_u (.clk_sys(clk_sys), .ce(ce), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .in_6bit(in_6bit), .second_dither_stage_en(dither_en),
    .pix_in_valid(pix_in_valid), .pix_in_ctl(pix_in_ctl),
    .pix_in_r(pix_in_r), .pix_in_g(pix_in_g), .pix_in_b(pix_in_b),
    .pix_out_valid(pix_out_valid), .pix_out_ctl(pix_out_ctl),
    .pix_out_r(pix_out_r), .pix_out_g(pix_out_g), .pix_out_b(pix_out_b),
    .dither_needed(dither_needed), .wb_active(wb_active));
  wbl_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  task automatic chk(input wbl_byte_t got, input wbl_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input wbl_byte_t a, input wbl_byte_t e);
    host_u.rd(a, rdat);
    chk(rdat, e);
  endtask
  // expected entry: left aligned index in 6-bit mode, patched red entry 5
  function automatic wbl_byte_t lut(input int p, input wbl_byte_t v);
    wbl_byte_t i;
    i = in_6bit ? {v[7:2], 2'b00} : v;
    return i ^ key[p] ^ ((p == 1 && i == 8'h05) ? patch : 8'h00);
  endfunction
  // pixel held steady, so any two-cycle-old sample is this one
  task automatic px(input wbl_byte_t v, input logic on);
    pix_in_valid <= 1'b1;
    pix_in_ctl   <= v[2:0];
    pix_in_r     <= v;
    pix_in_g     <= v + 8'h01;
    pix_in_b     <= v + 8'h02;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(pix_out_r, on ? lut(1, v) : v);
    chk(pix_out_g, on ? lut(2, v + 8'h01) : v + 8'h01);
    chk(pix_out_b, on ? lut(3, v + 8'h02) : v + 8'h02);
    chk({6'h00, wb_active, dither_needed},
        {6'h00, on, on & in_6bit & dither_en});
    @(posedge clk_sys);
  endtask
  task automatic do_rst();
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
  endtask
  task automatic t_regs();
    do_rst();
    rchk(`WBL_CTRL_ADDR, `WBL_CTRL_RESET);
    host_u.wr(`WBL_CTRL_ADDR, 8'h3F);
    rchk(`WBL_CTRL_ADDR, 8'h30);
    rchk(8'h10, 8'h00);
    rchk(`WBL_STAT_ADDR, 8'h11);
  endtask
  task automatic t_load();
    for (int p = 1; p < 4; p++) begin
      do_rst();
      host_u.fill(2'(p), key[p]);
      rchk(8'h00, key[p]);
      rchk(`WBL_CTRL_ADDR, `WBL_CTRL_ADDR ^ key[p]);
      rchk(8'hFF, 8'hFF ^ key[p]);
    end
  endtask
  task automatic t_enable();
    do_rst();
    host_u.wr(`WBL_CTRL_ADDR, 8'h20); // tables all loaded
    host_u.idle();
    px(8'h00, 1'b1);
    px(8'hFE, 1'b1);
    in_6bit   <= 1'b1;
    dither_en <= 1'b1;
    px(8'h13, 1'b1);
    in_6bit   <= 1'b0;
    dither_en <= 1'b0;
    host_u.wr(`WBL_CTRL_ADDR, 8'h00);
    host_u.idle();
    px(8'h40, 1'b0);
  endtask
  task automatic t_lock();
    do_rst();
    host_u.wr(`WBL_CTRL_ADDR, 8'h20);
    host_u.wr(`WBL_CTRL_ADDR, 8'h60);
    host_u.wr(8'h05, 8'h05 ^ key[1] ^ 8'hFF);
    host_u.idle();
    px(8'h05, 1'b1);
    rchk(8'h05, 8'h05 ^ key[1]);
  endtask
  task automatic t_reload();
    do_rst();
    host_u.wr(`WBL_CTRL_ADDR, 8'h70);
    host_u.idle();
    px(8'h05, 1'b1);
    host_u.wr(8'h05, 8'h05 ^ key[1] ^ 8'hFF);
    host_u.idle();
    patch = 8'hFF;
    px(8'h05, 1'b1);
    px(8'h06, 1'b1);
  endtask
  // clock enable low: the pipeline must hold its last pixel
  task automatic t_freeze();
    px(8'h22, 1'b0);
    ce       <= 1'b0;
    pix_in_r <= 8'h77;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(pix_out_r, 8'h22);
    @(posedge clk_sys);
    ce       <= 1'b1;
  endtask
  task automatic finish_test();
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    t_regs();
    t_load();
    t_enable();
    t_freeze();
    t_lock();
    t_reload();
    finish_test();
  end
  // watchdog, well beyond the roughly 900 cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
endmodule
bind wbl_top wbl_top_sva chk_u (.clk_sys(clk_sys), .ce(ce), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .in_6bit(in_6bit),
  .second_dither_stage_en(second_dither_stage_en),
  .pix_in_valid(pix_in_valid), .pix_in_ctl(pix_in_ctl),
  .pix_in_r(pix_in_r), .pix_out_valid(pix_out_valid),
  .pix_out_ctl(pix_out_ctl), .pix_out_r(pix_out_r),
  .dither_needed(dither_needed), .wb_active(wb_active));
